/* core/i2cbrg_top.sv */
`timescale 1ns/1ps
`default_nettype none
module i2cbrg_top (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  output logic             irq
);

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0]                rate_reload_value_r;
  logic [7:0]                serial_data_buffer_r;
  logic [7:0]                serial_control_one_r;
  logic [7:0]                serial_control_two_r;
  logic                      stop_seen_r;
  logic                      scl_low_r;
  logic                      sda_low_r;
  logic [3:0]                half_cnt_r;
  i2cbrg_pkg::i2cbrg_state_t state_r;
  logic                      aw_hold_r;
  logic                      w_hold_r;
  logic [7:0]                aw_addr_r;
  logic [31:0]               w_data_r;
  logic [3:0]                w_strb_r;
  logic                      wr_fire;
  logic                      wr_hit;
  logic                      rd_hit;
  logic                      run;
  logic                      reload;
  logic                      expired;
  logic                      coll;
  logic                      done;
  logic                      buf_write;
  logic [1:0]                flags;
  logic [1:0]                enables;
  logic [7:0]                rd_byte;

  function automatic logic known_addr(input logic [7:0] a);
    known_addr = (a == i2cbrg_pkg::OFF_RELOAD) || (a == i2cbrg_pkg::OFF_DATA)
              || (a == i2cbrg_pkg::OFF_CTRL1) || (a == i2cbrg_pkg::OFF_CTRL2)
              || (a == i2cbrg_pkg::OFF_STATUS) || (a == i2cbrg_pkg::OFF_IRQ_FLG)
              || (a == i2cbrg_pkg::OFF_IRQ_EN);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Write channel: address and data are latched independently, any order.
  assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold_r && !s_axi_bvalid;
  assign wr_fire       = aw_hold_r && w_hold_r;
  assign wr_hit        = wr_fire && known_addr(aw_addr_r);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r  <= 32'h0;
      w_strb_r  <= 4'h0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      else if (wr_fire)
        aw_hold_r <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      else if (wr_fire)
        w_hold_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
    end
    else if (wr_fire)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_hit ? 2'b00 : 2'b10;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Software registers; only byte lane 0 carries data.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rate_reload_value_r  <= i2cbrg_pkg::RELOAD_RST;
      serial_data_buffer_r <= 8'h00;
      serial_control_one_r <= i2cbrg_pkg::CTRL_RST;
    end
    else if (wr_hit && w_strb_r[0])
    begin
      if (aw_addr_r == i2cbrg_pkg::OFF_RELOAD)
        rate_reload_value_r <= w_data_r[7:0];
      if (aw_addr_r == i2cbrg_pkg::OFF_CTRL1)
        serial_control_one_r <= w_data_r[7:0];
      if (buf_write)
        serial_data_buffer_r <= w_data_r[7:0];
    end
  end

  // A buffer write is ignored while a condition is on the bus.
  assign buf_write = wr_hit && w_strb_r[0] && (aw_addr_r == i2cbrg_pkg::OFF_DATA)
                  && (state_r == i2cbrg_pkg::ST_IDLE);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      serial_control_two_r <= i2cbrg_pkg::CTRL_RST;
    else if (coll)
      serial_control_two_r <= 8'h00;
    else if (done)
      serial_control_two_r <= 8'h00;
    else if (wr_hit && w_strb_r[0] && aw_addr_r == i2cbrg_pkg::OFF_CTRL2
             && state_r == i2cbrg_pkg::ST_IDLE)
      serial_control_two_r <= w_data_r[7:0];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read channel.
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_hit        = known_addr(s_axi_araddr);

  always_comb
  begin
    case (s_axi_araddr)
      i2cbrg_pkg::OFF_RELOAD:  rd_byte = rate_reload_value_r;
      i2cbrg_pkg::OFF_DATA:    rd_byte = serial_data_buffer_r;
      i2cbrg_pkg::OFF_CTRL1:   rd_byte = serial_control_one_r;
      i2cbrg_pkg::OFF_CTRL2:   rd_byte = serial_control_two_r;
      i2cbrg_pkg::OFF_STATUS:  rd_byte = {3'h0, stop_seen_r, 3'h0,
                                          state_r != i2cbrg_pkg::ST_IDLE};
      i2cbrg_pkg::OFF_IRQ_FLG: rd_byte = {6'h00, flags};
      i2cbrg_pkg::OFF_IRQ_EN:  rd_byte = {6'h00, enables};
      default:                 rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= 2'b00;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= {24'h0, rd_byte};
      s_axi_rresp  <= rd_hit ? 2'b00 : 2'b10;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer for repeated start, stop and the byte clock.
  assign done = (state_r == i2cbrg_pkg::ST_RS_END && expired)
             || (state_r == i2cbrg_pkg::ST_SP_CHK && expired && sda_i)
             || (state_r == i2cbrg_pkg::ST_BYTE && expired && half_cnt_r == 4'hf);

  always_comb
  begin
    coll   = 1'b0;
    reload = 1'b0;
    case (state_r)
      i2cbrg_pkg::ST_IDLE:
        reload = buf_write;
      i2cbrg_pkg::ST_RS_REL:
        reload = sda_i;
      i2cbrg_pkg::ST_RS_HI:
      begin
        coll   = scl_i && !sda_i;
        reload = scl_i && sda_i;
      end
      i2cbrg_pkg::ST_RS_SDA:
      begin
        coll   = !scl_i && sda_i;
        reload = expired && scl_i && sda_i;
      end
      i2cbrg_pkg::ST_SP_CLK:
      begin
        coll   = !scl_i && scl_low_r == 1'b0;
        reload = scl_i;
      end
      i2cbrg_pkg::ST_SP_HI:
        coll = !scl_i;
      i2cbrg_pkg::ST_SP_CHK:
        coll = expired && !sda_i;
      i2cbrg_pkg::ST_BYTE:
        reload = expired && half_cnt_r != 4'hf;
      default:
      begin
        coll   = 1'b0;
        reload = 1'b0;
      end
    endcase
  end

  assign run = (state_r != i2cbrg_pkg::ST_IDLE);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_r    <= i2cbrg_pkg::ST_IDLE;
      scl_low_r  <= 1'b0;
      sda_low_r  <= 1'b0;
      half_cnt_r <= 4'h0;
    end
    else if (coll)
    begin
      state_r   <= i2cbrg_pkg::ST_IDLE;
      scl_low_r <= 1'b0;
      sda_low_r <= 1'b0;
    end
    else
    begin
      case (state_r)
        i2cbrg_pkg::ST_IDLE:
          if (buf_write)
          begin
            state_r    <= i2cbrg_pkg::ST_BYTE;
            half_cnt_r <= 4'h0;
            scl_low_r  <= 1'b1;
          end
          else if (serial_control_two_r[i2cbrg_pkg::CTRL2_REPEATED_START_ENABLE])
          begin
            state_r   <= i2cbrg_pkg::ST_RS_REL;
            sda_low_r <= 1'b0;
          end
          else if (serial_control_two_r[i2cbrg_pkg::CTRL2_PEN])
          begin
            state_r   <= i2cbrg_pkg::ST_SP_LO;
            sda_low_r <= 1'b1;
          end
        i2cbrg_pkg::ST_RS_REL:
          if (sda_i)
            state_r <= i2cbrg_pkg::ST_RS_LO;
        i2cbrg_pkg::ST_RS_LO:
          if (expired)
          begin
            scl_low_r <= 1'b0;
            state_r   <= i2cbrg_pkg::ST_RS_HI;
          end
        i2cbrg_pkg::ST_RS_HI:
          if (scl_i)
            state_r <= i2cbrg_pkg::ST_RS_SDA;
        i2cbrg_pkg::ST_RS_SDA:
          if (!sda_i || expired)
          begin
            sda_low_r <= 1'b1;
            state_r   <= i2cbrg_pkg::ST_RS_END;
          end
        i2cbrg_pkg::ST_RS_END:
          if (expired)
          begin
            scl_low_r <= 1'b1;
            state_r   <= i2cbrg_pkg::ST_IDLE;
          end
        i2cbrg_pkg::ST_SP_LO:
          if (!sda_i)
          begin
            scl_low_r <= 1'b0;
            state_r   <= i2cbrg_pkg::ST_SP_CLK;
          end
        i2cbrg_pkg::ST_SP_CLK:
          if (scl_i)
            state_r <= i2cbrg_pkg::ST_SP_HI;
        i2cbrg_pkg::ST_SP_HI:
          if (expired)
          begin
            sda_low_r <= 1'b0;
            state_r   <= i2cbrg_pkg::ST_SP_CHK;
          end
        i2cbrg_pkg::ST_SP_CHK:
          if (expired)
            state_r <= i2cbrg_pkg::ST_IDLE;
        i2cbrg_pkg::ST_BYTE:
          if (expired)
          begin
            scl_low_r  <= ~scl_low_r;
            half_cnt_r <= half_cnt_r + 4'h1;
            if (half_cnt_r == 4'hf)
              state_r <= i2cbrg_pkg::ST_IDLE;
          end
        default:
          state_r <= i2cbrg_pkg::ST_IDLE;
      endcase
    end
  end

  // The stop flag shows a completed stop condition until the next repeated start.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      stop_seen_r <= 1'b0;
    else if (state_r == i2cbrg_pkg::ST_SP_CHK && expired && sda_i)
      stop_seen_r <= 1'b1;
    else if (state_r == i2cbrg_pkg::ST_RS_REL)
      stop_seen_r <= 1'b0;
  end

  // Open-drain outputs: drive low or release, never drive high.
  assign scl_o  = 1'b0;
  assign sda_o  = 1'b0;
  assign scl_oe = scl_low_r;
  assign sda_oe = sda_low_r;

  ////////////////////////////////////////////////////////////////////////////
  i2cbrg_rate u_rate (
    .aclk         (aclk),
    .aresetn      (aresetn),
    .run          (run),
    .reload       (reload),
    .reload_value (rate_reload_value_r),
    .expired      (expired)
  );

  i2cbrg_irq u_irq (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .set_evt  ({coll, done}),
    .clr_we   (wr_hit && w_strb_r[0] && aw_addr_r == i2cbrg_pkg::OFF_IRQ_FLG),
    .clr_bits (w_data_r[1:0]),
    .en_we    (wr_hit && w_strb_r[0] && aw_addr_r == i2cbrg_pkg::OFF_IRQ_EN),
    .en_bits  (w_data_r[1:0]),
    .flags    (flags),
    .enables  (enables),
    .irq      (irq)
  );

endmodule
`default_nettype wire

/* core/i2cbrg_pkg.sv */
package i2cbrg_pkg;

  // Register byte offsets on the AXI4-Lite slave.
  localparam logic [7:0] OFF_RELOAD  = 8'h00;
  localparam logic [7:0] OFF_DATA    = 8'h04;
  localparam logic [7:0] OFF_CTRL1   = 8'h08;
  localparam logic [7:0] OFF_CTRL2   = 8'h0c;
  localparam logic [7:0] OFF_STATUS  = 8'h10;
  localparam logic [7:0] OFF_IRQ_FLG = 8'h14;
  localparam logic [7:0] OFF_IRQ_EN  = 8'h18;

  // Control-two field positions.
  localparam int CTRL2_SEN   = 0;
  localparam int CTRL2_REPEATED_START_ENABLE  = 1;
  localparam int CTRL2_PEN   = 2;
  localparam int CTRL2_ACK_SEQUENCE_ENABLE = 4;

  // Control-one fields: port_mode_select in [3:0], port enable in bit 5.
  localparam int CTRL1_EN    = 5;

  // Interrupt flag positions.
  localparam int IRQ_SERIAL  = 0;
  localparam int IRQ_COLL    = 1;

  // Status field positions.
  localparam int STAT_STOP   = 4;
  localparam int STAT_BUSY   = 0;

  // Reset values.
  localparam logic [7:0] RELOAD_RST = 8'h00;
  localparam logic [7:0] CTRL_RST   = 8'h00;

  // Mode codes of port_mode_select.
  localparam logic [3:0] MODE_I2C_MASTER = 4'h8;

  // Last divider value. The counter steps every second clock, so two rollovers
  // make one line period of four times (reload + 1) clocks.
  localparam logic [1:0] TICK_DIV_LAST = 2'h1;

  typedef enum logic [3:0] {
    ST_IDLE   = 4'b0000,
    ST_RS_REL = 4'b0001,
    ST_RS_LO  = 4'b0010,
    ST_RS_HI  = 4'b0011,
    ST_RS_SDA = 4'b0100,
    ST_RS_END = 4'b0101,
    ST_SP_LO  = 4'b0110,
    ST_SP_CLK = 4'b0111,
    ST_SP_HI  = 4'b1000,
    ST_SP_CHK = 4'b1001,
    ST_BYTE   = 4'b1010
  } i2cbrg_state_t;

endpackage

/* core/i2cbrg_rate.sv */
`timescale 1ns/1ps
`default_nettype none
module i2cbrg_rate (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       run,
  input  wire logic       reload,
  input  wire logic [7:0] reload_value,
  output logic            expired
);
  logic [1:0] div_r;
  logic [7:0] count_r;
  logic       tick;

  // The divider wraps at its last value, giving one tick every second clock.
  always_ff @(posedge aclk)
  begin
    if (!aresetn || !run || tick)
      div_r <= 2'h0;
    else
      div_r <= div_r + 2'h1;
  end
  assign tick = (div_r == i2cbrg_pkg::TICK_DIV_LAST);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      count_r <= 8'h00;
    else if (reload)
      count_r <= reload_value;
    else if (run && tick && count_r != 8'h00)
      count_r <= count_r - 8'h01;
  end

  // Expiry must not look at reload, which itself depends on expiry in some states.
  assign expired = run && tick && (count_r == 8'h00);
endmodule
`default_nettype wire

/* core/i2cbrg_irq.sv */
`timescale 1ns/1ps
`default_nettype none
module i2cbrg_irq (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [1:0] set_evt,
  input  wire logic       clr_we,
  input  wire logic [1:0] clr_bits,
  input  wire logic       en_we,
  input  wire logic [1:0] en_bits,
  output logic      [1:0] flags,
  output logic      [1:0] enables,
  output logic            irq
);
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      flags <= 2'h0;
    else
      flags <= (flags & ~(clr_we ? clr_bits : 2'h0)) | set_evt;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      enables <= 2'h0;
    else if (en_we)
      enables <= en_bits;
  end

  assign irq = |(flags & enables);
endmodule
`default_nettype wire

/* test/i2cbrg_top_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module i2cbrg_top_properties (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        scl_i,
  input wire logic        scl_o,
  input wire logic        scl_oe,
  input wire logic        sda_i,
  input wire logic        sda_o,
  input wire logic        sda_oe,
  input wire logic        irq
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  ////////////////////////////////////////////////////////////////////////////////
  // Collision windows allow a few cycles for the sequencer and flag register.
  rs_sda_low_a: assert property ($rose(scl_i) && !sda_i && !scl_oe && !sda_oe
    |-> ##[1:8] irq) else $error("no collision after clock rose with data low");
  rs_scl_fall_a: assert property ($fell(scl_i) && sda_i && !scl_oe && !sda_oe
    |-> ##[1:8] (irq && !scl_oe && !sda_oe)) else $error("early clock fall not flagged");
  half_period_a: assert property ($changed(scl_oe) |=> $stable(scl_oe) [*6])
    else $error("clock half period too short");
  coll_release_a: assert property ($rose(irq) && !scl_oe |-> !sda_oe)
    else $error("data line still pulled at event");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
  open_drain_a: assert property (!scl_o && !sda_o) else $error("line driven high");
  reset_quiet_a: assert property (disable iff (1'b0) !aresetn
    |=> !scl_oe && !sda_oe && !s_axi_bvalid && !s_axi_rvalid && !irq)
    else $error("outputs active in reset");

  cover property ($rose(irq) && !scl_oe);
  cover property ($fell(scl_i) && sda_oe && !scl_oe);
  cover property (scl_oe && sda_oe);
endmodule

bind i2cbrg_top i2cbrg_top_properties i_i2cbrg_top_properties (
  .aclk, .aresetn, .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid, .s_axi_rready,
  .s_axi_rdata, .scl_i, .scl_o, .scl_oe, .sda_i, .sda_o, .sda_oe, .irq
);
`default_nettype wire

/* test/i2cbrg_bus_model.sv */
`timescale 1ns/1ps
`default_nettype none
module i2cbrg_bus_model (
  input  wire logic aclk,
  input  wire logic dut_scl_oe,
  input  wire logic dut_sda_oe,
  input  wire logic pull_scl,
  input  wire logic pull_sda,
  output logic      scl,
  output logic      sda,
  output var int    scl_period
);
  int   cnt   = 0;
  logic scl_q = 1'b1;

  ////////////////////////////////////////////////////////////////////////////////
  // Both lines are wired-and with pull-ups, so a released line reads high.
  assign scl = !(dut_scl_oe || pull_scl);
  assign sda = !(dut_sda_oe || pull_sda);

  ////////////////////////////////////////////////////////////////////////////////
  // Cycles between clock falls; a stretched clock shows up as a long period.
  always_ff @(posedge aclk)
  begin
    scl_q <= scl;
    cnt   <= (scl_q && !scl) ? 1 : cnt + 1;
    if (scl_q && !scl)
      scl_period <= cnt;
  end
endmodule
`default_nettype wire

/* test/i2cbrg_top_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module i2cbrg_top_tb;
  localparam logic [7:0] RLD = i2cbrg_pkg::OFF_RELOAD;
  localparam logic [7:0] C2  = i2cbrg_pkg::OFF_CTRL2;
  localparam logic [7:0] FLG = i2cbrg_pkg::OFF_IRQ_FLG;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00;
  logic        s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0;
  logic [7:0]  s_axi_araddr = 8'h00;
  logic        s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [31:0] s_axi_rdata, d;
  logic        scl_i, scl_o, scl_oe, sda_i, sda_o, sda_oe, irq, hold;
  logic        pull_scl = 1'b0;
  logic        pull_sda = 1'b0;
  int          scl_period, half;
  int          errors = 0;
  int          n_checks = 0;
  int          rv[3] = '{5, 3, 99};

  i2cbrg_top i_i2cbrg_top (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .scl_i, .scl_o, .scl_oe, .sda_i, .sda_o, .sda_oe, .irq
  );
  i2cbrg_bus_model i_i2cbrg_bus_model (
    .aclk, .dut_scl_oe(scl_oe), .dut_sda_oe(sda_oe), .pull_scl, .pull_sda,
    .scl(scl_i), .sda(sda_i), .scl_period
  );

  always #12.5 aclk = ~aclk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Each bus task waits an edge first, so a handshake signal is never set twice in one step.
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
      r = s_axi_bresp;
    end
    while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
      d = s_axi_rdata;
      r = s_axi_rresp;
    end
    while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
    rd(a);
    chk(nm, e, d);
  endtask

  task automatic wait_irq;
    for (int t = 0; t < 5000 && irq !== 1'b1; t++)
      @(posedge aclk);
    chk("irq", 32'h1, {31'h0, irq});
  endtask

  task automatic fin(input logic [31:0] f, input logic so, input logic dd);
    wait_irq();
    rchk(FLG, f, "flags");
    rchk(C2, 32'h0, "ctrl2");
    chk("scl_oe", {31'h0, so}, {31'h0, scl_oe});
    chk("sda_oe", {31'h0, dd}, {31'h0, sda_oe});
    wr(FLG, f);
    chk("irq_clr", 32'h0, {31'h0, irq});
    pull_scl <= 1'b0;
    pull_sda <= 1'b0;
  endtask

  task automatic results;
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (40000) @(posedge aclk);
    errors++;
    results();
  end

  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(RLD, {24'h0, i2cbrg_pkg::RELOAD_RST}, "reload_rst");
    rchk(C2, {24'h0, i2cbrg_pkg::CTRL_RST}, "ctrl2_rst");
    rchk(FLG, 32'h0, "flags_rst");
    rd(8'h1c);
    chk("bad_resp", 32'h2, {30'h0, r});
    chk("bad_data", 32'h0, d);
    wr(8'h1c, 32'h0);
    chk("bad_wresp", 32'h2, {30'h0, r});
    wr(i2cbrg_pkg::OFF_CTRL1, (32'h1 << i2cbrg_pkg::CTRL1_EN) | 32'(i2cbrg_pkg::MODE_I2C_MASTER));
    chk("ok_wresp", 32'h0, {30'h0, r});
    wr(i2cbrg_pkg::OFF_IRQ_EN, 32'h3);
    // Reload values stay at three or above; the last keeps the line at 100 kHz.
    foreach (rv[i])
    begin
      wr(RLD, rv[i]);
      rchk(RLD, rv[i], "reload");
      wr(i2cbrg_pkg::OFF_DATA, 32'ha5);
      wait_irq();
      chk("period", 4 * (rv[i] + 1), scl_period);
      hold = scl_oe;
      repeat (40) @(posedge aclk);
      chk("scl_hold", {31'h0, hold}, {31'h0, scl_oe});
      rchk(FLG, 32'h1, "done_flag");
      wr(FLG, 32'h1);
    end
    rchk(i2cbrg_pkg::OFF_DATA, 32'ha5, "data_buf");
    half = scl_period / 2;
    wr(C2, 32'h2);
    for (int t = 0; t < 3000 && sda_oe !== 1'b1; t++)
      @(posedge aclk);
    chk("sda_first", 32'h0, {31'h0, scl_oe});
    fin(32'h1, 1'b1, 1'b1);
    wr(C2, 32'h4);
    fin(32'h1, 1'b0, 1'b0);
    rd(i2cbrg_pkg::OFF_STATUS);
    chk("stop_seen", 32'h1, {31'h0, d[i2cbrg_pkg::STAT_STOP]});
    wr(C2, 32'h2);
    repeat (half * 3 / 2) @(posedge aclk);
    pull_sda <= 1'b1;
    fin(32'h1, 1'b1, 1'b1);
    wr(C2, 32'h4);
    repeat (half / 2) @(posedge aclk);
    pull_scl <= 1'b1;
    fin(32'h2, 1'b0, 1'b0);
    wr(i2cbrg_pkg::OFF_IRQ_EN, 32'h1);
    wr(C2, 32'h4);
    repeat (4) @(posedge aclk);
    pull_sda <= 1'b1;
    repeat (half * 4) @(posedge aclk);
    chk("irq_masked", 32'h0, {31'h0, irq});
    wr(i2cbrg_pkg::OFF_IRQ_EN, 32'h3);
    fin(32'h2, 1'b0, 1'b0);
    wr(C2, 32'h2);
    repeat (half * 3 / 2) @(posedge aclk);
    pull_scl <= 1'b1;
    fin(32'h2, 1'b0, 1'b0);
    wr(C2, 32'h2);
    repeat (4) @(posedge aclk);
    pull_sda <= 1'b1;
    repeat (4) @(posedge aclk);
    pull_scl <= 1'b1;
    repeat (half * 2) @(posedge aclk);
    pull_scl <= 1'b0;
    fin(32'h2, 1'b0, 1'b0);
    results();
  end
endmodule
`default_nettype wire
